// ==== pkg/wmd_pkg.sv ====
// Purpose : Constants for the writable microword field decoder
// Assumes : 10 MHz clk, classic Wishbone register access, 32-bit data
// Notes   : Microword bit positions are absolute indices into the 80-bit word
package wmd_pkg;

    // ============================================================
    // Register map (byte addresses)
    localparam logic [7:0] WMD_GRP0_OFF = 8'h00;
    localparam logic [7:0] WMD_GRP1_OFF = 8'h04;
    localparam logic [7:0] WMD_GRP2_OFF = 8'h08;
    localparam logic [7:0] WMD_GRP3_OFF = 8'h0C;
    localparam logic [7:0] WMD_GRP4_OFF = 8'h10;
    localparam logic [7:0] WMD_NEXT_OFF = 8'h14;
    localparam logic [7:0] WMD_CTRL_OFF = 8'h18;
    localparam logic [7:0] WMD_STAT_OFF = 8'h1C;

    // Control register fields
    localparam int CTRL_START_BIT   = 0;
    localparam int CTRL_RESTART_BIT = 1;
    localparam int CTRL_SRI_BIT     = 2;
    localparam int CTRL_RML_LO      = 4;

    // Status register fields
    localparam int STAT_BUSY_BIT    = 0;
    localparam int STAT_STOP_BIT    = 1;
    localparam int STAT_CARRY_BIT   = 2;
    localparam int STAT_EXT_BIT     = 3;

    // ============================================================
    // Microword layout
    localparam int WORD_BITS   = 80;
    localparam int GROUP_COUNT = 5;
    localparam int GROUP_BITS  = 16;
    localparam int XU_RIF_LO   = 0;
    localparam int XU_DAD_LO   = 32;
    localparam int XU_BUS_LO   = 36;
    localparam int XU_BA_LOAD  = 39;
    localparam int XU_D_LOAD   = 40;
    localparam int XU_B_LOAD   = 41;
    localparam int XU_IR_LOAD  = 44;
    localparam int XU_STOP     = 45;
    localparam int XU_CLK_LO   = 46;
    localparam int XU_MSC_LO   = 59;
    localparam int XU_STACK_TARGET_CODE_LO  = 62;
    localparam int XU_IMMEDIATE_CONSTANT_FIELD_LO  = 64;
    localparam int XU_LML_LO   = 64;
    localparam int XU_CARRY    = 76;
    localparam int XU_PERMIT   = 77;

    // Extension is live only at or above this next address
    localparam logic [15:0] EXT_MIN_ADDR = 16'h0100;
    // Console address of general register 0 (octal 777700)
    localparam logic [17:0] CONSOLE_REG_BASE = 18'o777700;

    // ============================================================
    // Field encodings
    localparam logic [2:0] BUS_DATI    = 3'h1;
    localparam logic [2:0] BUS_AWAIT   = 3'h2;
    localparam logic [2:0] BUS_DATIP   = 3'h3;
    localparam logic [2:0] BUS_DATO    = 3'h5;
    localparam logic [2:0] BUS_RESTART = 3'h6;
    localparam logic [2:0] BUS_DATOB   = 3'h7;

    localparam logic [3:0] DAD_NOP     = 4'h0;
    localparam logic [3:0] DAD_BYTE    = 4'h1;
    localparam logic [3:0] DAD_STACK   = 4'h3;
    localparam logic [3:0] DAD_CARRY   = 4'h4;
    localparam logic [3:0] DAD_FIR     = 4'h6;
    localparam logic [3:0] DAD_INHIBIT = 4'h7;

    localparam logic [1:0] STACK_TARGET_CODE_OFF    = 2'h0;
    localparam logic [1:0] STACK_TARGET_CODE_PUSH   = 2'h1;
    localparam logic [1:0] STACK_TARGET_CODE_READ   = 2'h2;
    localparam logic [1:0] STACK_TARGET_CODE_WRITE  = 2'h3;

    localparam logic [2:0] MSC_CONST   = 3'h1;

    // ============================================================
    // Phase timing
    localparam int CLK_NS = 100;
    localparam int P1_NS  = 140;
    localparam int P2_NS  = 200;
    localparam int P3_NS  = 300;
    localparam logic [1:0] P1_CYC = 2'((P1_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [1:0] P2_CYC = 2'((P2_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [1:0] P3_CYC = 2'((P3_NS + CLK_NS - 1) / CLK_NS);

endpackage

// ==== logic/wmd_decoder.sv ====
// Purpose : Decode the 80-bit writable microword into data path strobes
// Assumes : Software loads five 16-bit groups, then starts one microcycle
// Notes   : Do not rewrite groups while a cycle is busy; decode is live
`timescale 1ns/10ps
module wmd_decoder
    import wmd_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Data path inputs
    input  wire logic [15:0] shifter_output,
    input  wire logic        carry_out_muxed,
    input  wire logic        status_carry,
    input  wire logic        ir_cmp_or_inc,
    input  wire logic        ir_add_carry,
    input  wire logic        ir_rotate_left,
    input  wire logic        ir_bit_cmp_test,
    // Phases and register strobes
    output logic             phase_p1,
    output logic             phase_p2,
    output logic             phase_p3,
    output logic             b_register_load,
    output logic             bus_address_load,
    output logic             d_register_load,
    output logic             instruction_register_load,
    output logic             processor_clock_run,
    // Bus controller requests
    output logic             bus_read,
    output logic             bus_read_pause,
    output logic             bus_write_word,
    output logic             bus_write_byte,
    output logic             await_bus_busy,
    output logic             restart_on_release,
    // Alteration and carry
    output logic             odd_address_allow,
    output logic             stack_overflow_check,
    output logic             alu_function_from_ir,
    output logic             alu_carry_in,
    // Extension
    output logic             extension_enable,
    output logic      [2:0]  extension_state,
    output logic             stack_push,
    output logic             stack_read_drive,
    output logic             stack_mem_write,
    output logic      [15:0] immediate_constant_field,
    output logic             immediate_constant_valid,
    output logic      [15:0] result_bus,
    output logic      [15:0] branch_condition_lines,
    // Register addressing
    output logic      [3:0]  register_select_field,
    output logic             register_select_valid
);

    // ============================================================
    // State
    typedef struct packed {
        logic [GROUP_COUNT-1:0][GROUP_BITS-1:0] grp;
        logic [15:0] next_addr;
        logic [3:0]  right_limit_mask;
        logic        immediate_register_select;
        logic        busy;
        logic [1:0]  cnt;
        logic        stopped;
        logic        carry_flop;
        logic [15:0] masked;
        logic        ack;
        logic [31:0] rdata;
    } wmd_state_t;

    wmd_state_t st_reg;
    wmd_state_t st_next;

    // ============================================================
    // Functions
    function automatic logic [15:0] left_mask(input logic [3:0] code);
        logic [15:0] m;
        m = '0;
        for (int i = 0; i < 16; i++) begin
            m[i] = (i <= int'(code));
        end
        return m;
    endfunction

    function automatic logic [15:0] right_mask(input logic [3:0] code);
        logic [15:0] m;
        m = '0;
        for (int i = 0; i < 16; i++) begin
            m[15-i] = (i <= int'(code));
        end
        return m;
    endfunction

    function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0]  sel);
        logic [15:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = data[7:0];
        end
        if (sel[1]) begin
            r[15:8] = data[15:8];
        end
        return r;
    endfunction

    // ============================================================
    // Field decode
    logic [WORD_BITS-1:0] xu;
    logic [2:0]  bus_code;
    logic [3:0]  dad;
    logic [1:0]  clk_code;
    logic [1:0]  stack_target_code;
    logic [2:0]  mask_shift_control;
    logic [1:0]  cyc_len;
    logic        cycle_end;
    logic        suppress;
    logic        ext_on;
    logic        use_const;
    logic [15:0] mask_now;

    assign xu        = st_reg.grp;
    assign bus_code  = xu[XU_BUS_LO +: 3];
    assign dad       = xu[XU_DAD_LO +: 4];
    assign clk_code  = xu[XU_CLK_LO +: 2];
    assign stack_target_code      = xu[XU_STACK_TARGET_CODE_LO +: 2];
    assign mask_shift_control       = xu[XU_MSC_LO +: 3];
    assign ext_on    = (st_reg.next_addr >= EXT_MIN_ADDR);
    assign use_const = ext_on && (mask_shift_control == MSC_CONST);
    // Test-type instructions under the inhibit code neither write nor stop
    assign suppress  = (dad == DAD_INHIBIT) && ir_bit_cmp_test;

    assign cyc_len   = clk_code[1] ? (clk_code[0] ? P3_CYC : P2_CYC) : P1_CYC;
    assign cycle_end = st_reg.busy && (st_reg.cnt == cyc_len - 2'h1);
    assign phase_p1  = cycle_end && !clk_code[1];
    assign phase_p2  = st_reg.busy && ((clk_code == 2'h2 && cycle_end)
                     || (clk_code == 2'h3 && st_reg.cnt == P2_CYC - 2'h1));
    assign phase_p3  = cycle_end && (clk_code == 2'h3);

    // ============================================================
    // Strobes
    assign b_register_load           = xu[XU_B_LOAD] && (phase_p1 || phase_p3);
    assign bus_address_load          = xu[XU_BA_LOAD] && (phase_p1 || phase_p2);
    assign d_register_load           = xu[XU_D_LOAD] && phase_p2;
    assign instruction_register_load = xu[XU_IR_LOAD] && (phase_p1 || phase_p3);
    assign processor_clock_run       = !st_reg.stopped;

    // Codes 000 and 100 match no request and leave the bus idle
    assign bus_read           = cycle_end && (bus_code == BUS_DATI);
    assign bus_read_pause     = cycle_end && (bus_code == BUS_DATIP);
    assign bus_write_word     = cycle_end && (bus_code == BUS_DATO) && !suppress;
    assign bus_write_byte     = cycle_end && (bus_code == BUS_DATOB) && !suppress;
    assign await_bus_busy     = cycle_end && (bus_code == BUS_AWAIT);
    assign restart_on_release = cycle_end && (bus_code == BUS_RESTART);

    assign odd_address_allow    = st_reg.busy && (dad == DAD_BYTE);
    assign stack_overflow_check = st_reg.busy && (dad == DAD_STACK);
    assign alu_function_from_ir = st_reg.busy && (dad == DAD_FIR);

    // Carry chain overrides any alteration-driven carry
    always_comb begin
        if (xu[XU_CARRY]) begin
            alu_carry_in = st_reg.carry_flop;
        end else if (dad == DAD_CARRY) begin
            alu_carry_in = 1'b1;
        end else if (dad == DAD_FIR) begin
            alu_carry_in = ir_cmp_or_inc || (ir_add_carry && status_carry)
                        || (ir_rotate_left && status_carry);
        end else begin
            alu_carry_in = 1'b0;
        end
    end

    // ============================================================
    // Extension
    assign extension_enable = ext_on;
    assign extension_state  = ext_on ? mask_shift_control : 3'h0;
    // Push needs the permit bit set; a plain stack-word write is not a push
    assign stack_push       = cycle_end && ext_on && xu[XU_PERMIT]
                            && (stack_target_code == STACK_TARGET_CODE_PUSH);
    assign stack_mem_write  = cycle_end && ext_on && !use_const
                            && (stack_target_code == STACK_TARGET_CODE_WRITE);
    assign stack_read_drive = st_reg.busy && ext_on && !use_const
                            && (stack_target_code == STACK_TARGET_CODE_READ);
    assign immediate_constant_field = xu[XU_IMMEDIATE_CONSTANT_FIELD_LO +: 16];
    assign immediate_constant_valid = st_reg.busy && use_const;
    // Constant use takes the low immediate bits, so no left limit then
    assign mask_now = use_const ? right_mask(st_reg.right_limit_mask)
                    : left_mask(xu[XU_LML_LO +: 4]) & right_mask(st_reg.right_limit_mask);
    assign result_bus             = st_reg.masked;
    assign branch_condition_lines = st_reg.masked;

    assign register_select_field = st_reg.immediate_register_select ? xu[XU_RIF_LO +: 4] : 4'h0;
    assign register_select_valid = st_reg.immediate_register_select;

    assign wb_dat_o = st_reg.rdata;
    assign wb_ack_o = st_reg.ack;

    // ============================================================
    // Next state
    always_comb begin
        logic req;
        logic wr;
        logic start;
        req     = 1'b0;
        wr      = 1'b0;
        start   = 1'b0;
        st_next = st_reg;
        req     = wb_cyc_i && wb_stb_i && !st_reg.ack;
        wr      = req && wb_we_i;
        st_next.ack = req;
        // Bus slave: registered single-cycle answer, unmapped reads give zero
        if (req) begin
            st_next.rdata = 32'h0;
            if (wb_adr_i == WMD_NEXT_OFF) begin
                st_next.rdata[15:0] = st_reg.next_addr;
            end else if (wb_adr_i == WMD_CTRL_OFF) begin
                st_next.rdata[CTRL_SRI_BIT] = st_reg.immediate_register_select;
                st_next.rdata[CTRL_RML_LO +: 4] = st_reg.right_limit_mask;
            end else if (wb_adr_i == WMD_STAT_OFF) begin
                st_next.rdata[STAT_BUSY_BIT]  = st_reg.busy;
                st_next.rdata[STAT_STOP_BIT]  = st_reg.stopped;
                st_next.rdata[STAT_CARRY_BIT] = st_reg.carry_flop;
                st_next.rdata[STAT_EXT_BIT]   = ext_on;
            end else if (wb_adr_i <= WMD_GRP4_OFF && wb_adr_i[1:0] == 2'h0) begin
                st_next.rdata[15:0] = st_reg.grp[wb_adr_i[4:2]];
            end
        end
        if (wr) begin
            if (wb_adr_i == WMD_NEXT_OFF) begin
                st_next.next_addr = lane_merge(st_reg.next_addr, wb_dat_i, wb_sel_i);
            end else if (wb_adr_i == WMD_CTRL_OFF && wb_sel_i[0]) begin
                st_next.immediate_register_select = wb_dat_i[CTRL_SRI_BIT];
                st_next.right_limit_mask = wb_dat_i[CTRL_RML_LO +: 4];
                start       = wb_dat_i[CTRL_START_BIT];
                if (wb_dat_i[CTRL_RESTART_BIT]) begin
                    st_next.stopped = 1'b0;
                end
            end else if (wb_adr_i <= WMD_GRP4_OFF && wb_adr_i[1:0] == 2'h0) begin
                st_next.grp[wb_adr_i[4:2]] =
                    lane_merge(st_reg.grp[wb_adr_i[4:2]], wb_dat_i, wb_sel_i);
            end
        end
        // Microcycle sequencing; a stopped clock refuses new cycles
        if (start && !st_reg.busy && !st_reg.stopped) begin
            st_next.busy = 1'b1;
            st_next.cnt  = 2'h0;
        end else if (cycle_end) begin
            st_next.busy = 1'b0;
            st_next.cnt  = 2'h0;
        end else if (st_reg.busy) begin
            st_next.cnt = st_reg.cnt + 2'h1;
        end
        if (cycle_end) begin
            // Stop set wins over a restart in the same cycle
            if (xu[XU_STOP] && !suppress) begin
                st_next.stopped = 1'b1;
            end
            if (xu[XU_CARRY]) begin
                st_next.carry_flop = carry_out_muxed;
            end
        end
        if (st_reg.busy && ext_on) begin
            st_next.masked = shifter_output & mask_now;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ============================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_ext_off_low: assert property ((st_reg.next_addr < EXT_MIN_ADDR) |->
        !stack_push && !stack_mem_write && !stack_read_drive && extension_state == 3'h0)
        else $error("extension active below address 256");
    a_bus_idle_codes: assert property ((bus_code == 3'h0 || bus_code == 3'h4) |->
        !(bus_read || bus_read_pause || bus_write_word || bus_write_byte
          || await_bus_busy || restart_on_release))
        else $error("idle bus code started a cycle");
    a_dato_gate: assert property (bus_write_word |->
        bus_code == BUS_DATO && cycle_end && !suppress)
        else $error("word write issued wrongly");
    a_b_load_phase: assert property (b_register_load |->
        xu[XU_B_LOAD] && (phase_p1 || phase_p3))
        else $error("B load outside P1 or P3");
    a_ba_load_phase: assert property ((st_reg.busy && xu[XU_BA_LOAD] && phase_p1) |->
        bus_address_load) else $error("bus address load missed");
    a_d_load_phase: assert property (d_register_load |-> phase_p2 && xu[XU_D_LOAD])
        else $error("D load outside P2");
    a_ir_load_phase: assert property (instruction_register_load |->
        xu[XU_IR_LOAD] && (phase_p1 || phase_p3)) else $error("IR load at wrong phase");
    a_clock_stop: assert property ((cycle_end && xu[XU_STOP] && !suppress) |=>
        !processor_clock_run) else $error("clock did not stop");
    a_p3_length: assert property (($rose(st_reg.busy) && clk_code == 2'h3) |->
        ##1 phase_p2 ##1 phase_p3) else $error("P3 cycle timing wrong");
    a_p1_length: assert property (($rose(st_reg.busy) && !clk_code[1]) |->
        !phase_p1 ##1 phase_p1) else $error("P1 cycle timing wrong");
    a_carry_chain: assert property ((cycle_end && xu[XU_CARRY]) |->
        alu_carry_in == st_reg.carry_flop ##1 st_reg.carry_flop == $past(carry_out_muxed))
        else $error("carry chain flop wrong");
    // Both limit masks, apart from the constant path, so the masker check stands alone
    logic [15:0] mask_both;
    assign mask_both = left_mask(xu[XU_LML_LO +: 4]) & right_mask(st_reg.right_limit_mask);
    a_mask_pass: assert property ((st_reg.busy && ext_on && !use_const) |=>
        result_bus == ($past(shifter_output) & $past(mask_both)))
        else $error("masked bit passed");
    a_push_permit: assert property (stack_push |->
        xu[XU_PERMIT] && cycle_end && stack_target_code == STACK_TARGET_CODE_PUSH)
        else $error("push without permit");
    a_stack_write: assert property (
        (cycle_end && ext_on && !use_const && stack_target_code == STACK_TARGET_CODE_WRITE) |->
        stack_mem_write && !stack_push) else $error("stack write missed");
    a_stack_read: assert property (
        (st_reg.busy && ext_on && !use_const && stack_target_code == STACK_TARGET_CODE_READ) |->
        stack_read_drive) else $error("stack read drive missed");
    a_const_valid: assert property (
        (st_reg.busy && ext_on && mask_shift_control == MSC_CONST) |->
        immediate_constant_valid && !stack_read_drive && !stack_mem_write)
        else $error("constant use not exclusive");
    a_reg_select: assert property (st_reg.immediate_register_select |->
        register_select_valid && register_select_field == xu[XU_RIF_LO +: 4])
        else $error("register select field wrong");
    a_forced_carry: assert property ((!xu[XU_CARRY] && dad == DAD_CARRY) |->
        alu_carry_in) else $error("forced carry-in missing");
    a_fir_carry: assert property (
        (!xu[XU_CARRY] && dad == DAD_FIR && ir_cmp_or_inc) |-> alu_carry_in)
        else $error("instruction carry-in missing");
    a_ext_state: assert property (ext_on |->
        extension_state == mask_shift_control) else $error("extension state not from field");
    a_byte_write: assert property (
        (cycle_end && bus_code == BUS_DATOB && !suppress) |->
        bus_write_byte && !bus_write_word) else $error("byte write missed");

endmodule

// ==== tb/wmd_dp_model.sv ====
// Purpose : Data path and bus controller stand-in that tallies decoder strobes
// Assumes : Every strobe is a one-cycle pulse sampled on the rising clk edge
// Notes   : Shifter data is all ones, so each mask bit shows on the result
`timescale 1ns/10ps
module wmd_dp_model (
    // Clock, reset and tally clear
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        clr,
    // Strobes from the decoder
    input  wire logic [13:0] ev,
    // Data path answers
    output logic      [15:0] shifter_output,
    output logic             carry_out_muxed,
    output int               cnt [14]
);
    // ========================================
    // Fixed answers and strobe tally
    assign shifter_output  = 16'hFFFF;
    assign carry_out_muxed = 1'b1;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= '{default: 0};
        end else begin
            for (int i = 0; i < 14; i++) begin
                if (clr) begin
                    cnt[i] <= 0;
                end else if (ev[i]) begin
                    cnt[i] <= cnt[i] + 1;
                end
            end
        end
    end
endmodule

// ==== tb/tb_top.sv ====
// Purpose : Self-checking bench for the writable microword decoder
// Assumes : Wishbone slave acks within a few cycles of each request
// Notes   : Strobes are counted by the data path model, not sampled here
`timescale 1ns/10ps
module tb_top import wmd_pkg::*; ;
    // ========================================
    // Signals
    logic        clk, rstn, cyc, stb, we, clr, sc, irb, ack, run, ext, cmo, ici, cin;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat, q;
    logic [2:0]  est;
    logic [15:0] sh, res, bcl;
    logic [3:0]  rsf;
    logic [79:0] w;
    wire  [13:0] ev;
    int          cnt [14];
    int          miscompares, num_checks, cycles;
    // Expected tallies of read, pause, word, byte, await, restart per bus code
    localparam logic [5:0] BUS_EXP [8] = '{6'h0, 6'h1, 6'h10, 6'h2, 6'h0, 6'h4, 6'h20, 6'h8};

    // ========================================
    // Design and partner
    wmd_decoder wmd_decoder_inst (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .shifter_output(sh), .carry_out_muxed(cmo), .status_carry(sc),
        .ir_cmp_or_inc(ici), .ir_add_carry(1'b0), .ir_rotate_left(1'b0),
        .ir_bit_cmp_test(irb), .phase_p1(ev[0]), .phase_p2(ev[1]), .phase_p3(ev[2]),
        .b_register_load(ev[3]), .bus_address_load(ev[4]), .d_register_load(ev[5]),
        .instruction_register_load(ev[6]), .processor_clock_run(run), .bus_read(ev[7]),
        .bus_read_pause(ev[8]), .bus_write_word(ev[9]), .bus_write_byte(ev[10]),
        .await_bus_busy(ev[11]), .restart_on_release(ev[12]), .odd_address_allow(),
        .stack_overflow_check(), .alu_function_from_ir(), .alu_carry_in(cin),
        .extension_enable(ext), .extension_state(est), .stack_push(ev[13]),
        .stack_read_drive(), .stack_mem_write(), .immediate_constant_field(),
        .immediate_constant_valid(), .result_bus(res), .branch_condition_lines(bcl),
        .register_select_field(rsf), .register_select_valid());
    wmd_dp_model wmd_dp_model_inst (.clk(clk), .rstn(rstn), .clr(clr), .ev(ev),
        .shifter_output(sh), .carry_out_muxed(cmo), .cnt(cnt));

    // ========================================
    // Shared tasks
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // Request stands until ack is sampled high at a rising edge; data taken there
    task automatic wbx(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= wr;
        adr  <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            miscompares++;
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic go(input logic [15:0] nxt, input logic [31:0] ctl);
        int n;
        for (int g = 0; g < GROUP_COUNT; g++) begin
            wbx(1'b1, 8'(4 * g), {16'h0, w[16*g +: 16]});
        end
        wbx(1'b1, WMD_NEXT_OFF, {16'h0, nxt});
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        wbx(1'b1, WMD_CTRL_OFF, ctl | 32'h1);
        n = 0;
        do begin
            wbx(1'b0, WMD_STAT_OFF, 32'h0);
            n++;
        end while (q[STAT_BUSY_BIT] !== 1'b0 && n < 20);
        chk(q[STAT_BUSY_BIT], 1'b0);
    endtask

    task automatic complete_run();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ========================================
    // Scenarios
    task automatic t_ext();
        w = '0;
        go(16'h00FF, 32'h0);
        chk(q[STAT_EXT_BIT], 1'b0);
        chk(ext, 1'b0);
        go(16'h0100, 32'h0);
        chk(ext, 1'b1);
    endtask

    task automatic t_bus();
        for (int c = 0; c < 8; c++) begin
            w = '0;
            w[XU_BUS_LO +: 3] = 3'(c);
            go(16'h0, 32'h0);
            for (int i = 0; i < 6; i++) begin
                chk(cnt[7+i], BUS_EXP[c][i]);
            end
        end
    endtask

    task automatic t_phase();
        logic p1, p2, p3;
        for (int k = 0; k < 4; k++) begin
            w = '0;
            w[XU_IR_LOAD:XU_BA_LOAD] = 6'h27;
            w[XU_CLK_LO +: 2] = 2'(k);
            go(16'h0, 32'h0);
            p1 = (k < 2);
            p2 = (k >= 2);
            p3 = (k == 3);
            chk(cnt[0], p1);
            chk(cnt[1], p2);
            chk(cnt[2], p3);
            chk(cnt[3], p1 | p3);
            chk(cnt[4], p1 | p2);
            chk(cnt[5], p2);
            chk(cnt[6], p1 | p3);
        end
    endtask

    // Inhibit code must hold off both the word write and the stop for test ops
    task automatic t_stop();
        w = '0;
        w[XU_STOP] = 1'b1;
        w[XU_BUS_LO +: 3] = BUS_DATO;
        w[XU_DAD_LO +: 4] = DAD_INHIBIT;
        irb <= 1'b1;
        go(16'h0, 32'h0);
        chk(q[STAT_STOP_BIT], 1'b0);
        chk(cnt[9], 0);
        irb <= 1'b0;
        go(16'h0, 32'h0);
        chk(q[STAT_STOP_BIT], 1'b1);
        chk(run, 1'b0);
        chk(cnt[9], 1);
        wbx(1'b1, WMD_CTRL_OFF, 32'h2);
        wbx(1'b0, WMD_STAT_OFF, 32'h0);
        chk(q[STAT_STOP_BIT], 1'b0);
    endtask

    // Forced and instruction-derived carry-in with the carry chain off
    task automatic t_alter();
        w = '0;
        w[XU_DAD_LO +: 4] = DAD_CARRY;
        go(16'h0, 32'h0);
        chk(cin, 1'b1);
        w[XU_DAD_LO +: 4] = DAD_FIR;
        go(16'h0, 32'h0);
        chk(cin, 1'b0);
        ici <= 1'b1;
        @(posedge clk);
        chk(cin, 1'b1);
        ici <= 1'b0;
    endtask

    task automatic t_ext_paths();
        w = '0;
        w[XU_CARRY] = 1'b1;
        go(16'h0, 32'h0);
        chk(q[STAT_CARRY_BIT], 1'b1);
        w = '0;
        w[XU_LML_LO +: 4] = 4'h3;
        w[XU_MSC_LO +: 3] = 3'h5;
        w[XU_RIF_LO +: 4] = 4'h5;
        go(16'h0100, 32'hC4);
        chk(res, 16'h0008);
        chk(bcl, 16'h0008);
        chk(est, 3'h5);
        chk(rsf, 4'h5);
        w = '0;
        w[XU_STACK_TARGET_CODE_LO +: 2] = STACK_TARGET_CODE_PUSH;
        go(16'h0100, 32'h0);
        chk(cnt[13], 0);
        w[XU_PERMIT] = 1'b1;
        go(16'h0100, 32'h0);
        chk(cnt[13], 1);
    endtask

    // ========================================
    // Clock, timeout and main sequence
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            complete_run();
        end
    end

    initial begin
        {rstn, cyc, stb, we, clr, sc, irb, ici} = '0;
        adr  = 8'h00;
        wdat = 32'h0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        t_ext();
        t_bus();
        t_phase();
        t_stop();
        t_alter();
        t_ext_paths();
        complete_run();
    end
endmodule
